/* File: core/smb_cfg_pkg.sv */
// shared constants and types for the two-wire configuration port
package smb_cfg_pkg;
  // 7-bit slave address; with the write bit appended it reads 8'hd2
  localparam logic [6:0] DEV_ADDR          = 7'h69;
  localparam int         CMD_BYTE_MODE_BIT = 7;
  // register byte offsets
  localparam int         FREQ_SOURCE_CONTROL = 0;
  // field positions in freq_source_control
  localparam int         FS_HIGH_BIT       = 7;
  localparam int         FS_MID_BIT        = 6;
  localparam int         FS_LOW_BIT        = 5;
  localparam int         MGMT_BIT          = 4;
  localparam int         RSVD_BIT          = 3;
  localparam int         MAIN_SEL_BIT      = 2;
  localparam int         SERIAL_ATA_CLOCK_SELECT_BIT      = 1;
  localparam int         RETAIN_BIT        = 0;
  // power-up values of the first register bytes, byte 0 in the low lane
  localparam int         RESET_BYTES       = 4;
  localparam logic [RESET_BYTES-1:0][7:0] CFG_RESET = {8'hff, 8'hff, 8'h03, 8'h01};
  // timing
  localparam int         SYS_CLK_NS        = 25;
  localparam int         SCL_PERIOD_NS     = 10000;
  localparam int         SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * SYS_CLK_NS);
  // host request kinds
  typedef enum logic [1:0] {
    OP_BYTE_WRITE  = 2'h0,
    OP_BYTE_READ   = 2'h1,
    OP_BLOCK_WRITE = 2'h2,
    OP_BLOCK_READ  = 2'h3
  } op_t;
endpackage

/* File: core/smb_link_if.sv */
// two-wire link joining the host end and the configuration slave
`timescale 1ns/1ps
interface smb_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // open-drain data line with pull-up: any enabled low driver wins
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport device (
    input  scl,
    input  sda,
    output dev_sda_out,
    output dev_sda_oe
  );
  modport host (
    output scl,
    output host_sda_out,
    output host_sda_oe,
    input  sda
  );
endinterface

/* File: core/pin_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_t;

  sync_t st;
  sync_t next_st;

  // a bit only moves once stages two and three agree
  always_comb begin
    next_st       = st;
    next_st.s1    = pin;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.level = ((st.s2 ~^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.level);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
endmodule

/* File: core/smb_cfg_slave.sv */
// configuration slave end: two-wire protocol engine and control byte 0
// How it works
// R1 - accepts byte/block write and read
// R2 - block bytes ascend from lowest, msb first
// R3 - answers only address 69, as d2 with write bit or d3 with read bit
// R4 - command bit 7 picks byte or block
// R5 - command bits 6:0 index single byte
// R6 - block write acks address, command, count, data
// R7 - count-skip input drops the block write count phase; block read still sends count
// R8 - block read: restart, read address, count
// R9 - data bytes until host not-acknowledges
// R10 - byte write acks address, command, data
// R11 - byte read sends one byte after restart
// R12 - all registers load defaults at reset
// R13 - host changes registers only at initialisation
// R14 - bits 7:5 show latched frequency selects
// R15 - management enable set by write or pin, sticky
// R16 - bit 2 selects main source clock
// R17 - bit 1 selects serial ata clock source
// R18 - bit 0 keeps configuration through power-down
// R19 - frequency selects latched once at power good, and followed every cycle while power good is high in test mode
// R20 - foreign address ignored until next start
// R21 - reserved bit 3 reads zero
`timescale 1ns/1ps
module smb_cfg_slave #(
  parameter int REG_BYTES = smb_cfg_pkg::RESET_BYTES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  smb_link_if.device                  link,
  input  wire logic                   count_skip,
  input  wire logic                   power_good_strobe,
  input  wire logic                   cpu_freq_select_high,
  input  wire logic                   cpu_freq_select_mid,
  input  wire logic                   cpu_freq_select_low,
  input  wire logic                   test_mode,
  input  wire logic                   mgmt_pin_request,
  input  wire logic                   power_down,
  output logic                        mgmt_mode_enable,
  output logic                        main_source_select,
  output logic                        serial_ata_clock_select,
  output logic                        powerdown_config_retain,
  output logic [2:0]                  cpu_freq_latched,
  output logic [REG_BYTES-1:0][7:0]   config_bytes
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_HACK = 6'h10,
    ST_SKIP = 6'h20
  } dstate_t;

  typedef enum logic [3:0] {
    K_ADDR  = 4'h1,
    K_CMD   = 4'h2,
    K_COUNT = 4'h4,
    K_DATA  = 4'h8
  } kind_t;

  typedef struct packed {
    dstate_t                  state;
    kind_t                    kind;
    logic [3:0]               cnt;
    logic [7:0]               shift;
    logic                     rd;
    logic                     send_count;
    logic [6:0]               index;
    logic                     scl_d;
    logic                     sda_d;
    logic                     sda_oe;
    logic                     fs_taken;
    logic [2:0]               fs;
    logic [REG_BYTES-1:0][7:0] regs;
  } dev_t;

  function automatic logic [REG_BYTES-1:0][7:0] init_regs();
    logic [REG_BYTES-1:0][7:0] r;
    r = '0;
    for (int i = 0; i < REG_BYTES && i < smb_cfg_pkg::RESET_BYTES; i++) begin
      r[i] = smb_cfg_pkg::CFG_RESET[i];
    end
    return r;
  endfunction

  localparam logic [REG_BYTES-1:0][7:0] REGS_RESET = init_regs();
  localparam logic [7:0] BYTE_TOTAL = 8'(REG_BYTES);
  localparam dev_t DEV_RESET = '{state: ST_IDLE, kind: K_ADDR, scl_d: 1'b1, sda_d: 1'b1,
                                 regs: REGS_RESET, default: '0};

  dev_t       st;
  dev_t       next_st;
  logic [8:0] pins;
  logic       scl;
  logic       sda;
  logic       pg;
  logic       pd;
  logic       mgmt_req;
  logic       tmode;
  logic [2:0] fs_pin;

  // every pin except count_skip and rst_b is synchronised into the sys_clk domain
  pin_sync #(.WIDTH(9), .RESET_LEVEL(9'h003)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin     ({power_down, mgmt_pin_request, test_mode, power_good_strobe,
                cpu_freq_select_high, cpu_freq_select_mid, cpu_freq_select_low,
                link.sda, link.scl}),
    .level   (pins)
  );

  assign scl      = pins[0];
  assign sda      = pins[1];
  assign fs_pin   = pins[4:2];
  assign pg       = pins[5];
  assign tmode    = pins[6];
  assign mgmt_req = pins[7];
  assign pd       = pins[8];

  function automatic logic [7:0] byte0_view(dev_t s);
    logic [7:0] b;
    b = s.regs[smb_cfg_pkg::FREQ_SOURCE_CONTROL];
    // R14 hardware select bits
    b[smb_cfg_pkg::FS_HIGH_BIT:smb_cfg_pkg::FS_LOW_BIT] = s.fs;
    // R21 reserved reads zero
    b[smb_cfg_pkg::RSVD_BIT] = 1'b0;
    return b;
  endfunction

  always_comb begin
    logic [7:0] rx;
    logic [7:0] tx;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       load;
    rx      = {st.shift[6:0], sda};
    tx      = 8'h00;
    rise    = scl && !st.scl_d;
    fall    = !scl && st.scl_d;
    start   = scl && st.scl_d && st.sda_d && !sda;
    stop    = scl && st.scl_d && !st.sda_d && sda;
    load    = 1'b0;
    next_st = st;
    next_st.scl_d = scl;
    next_st.sda_d = sda;
    // R2 count first, then bytes from the current index upward
    if (st.send_count) begin
      tx = BYTE_TOTAL;
    end else if (st.index == 7'h00) begin
      tx = byte0_view(st);
    end else if (int'(st.index) < REG_BYTES) begin
      tx = st.regs[st.index];
    end
    if (start) begin
      next_st.state  = ST_RX;
      next_st.kind   = K_ADDR;
      next_st.cnt    = 4'h0;
      next_st.rd     = 1'b0;
      next_st.sda_oe = 1'b0;
    end else if (stop) begin
      next_st.state  = ST_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      unique case (st.state)
        ST_RX: begin
          if (rise) begin
            next_st.shift = rx;
            next_st.cnt   = st.cnt + 4'h1;
            if (st.cnt == 4'h7) begin
              next_st.state = ST_ACK;
              unique case (st.kind)
                K_ADDR: begin
                  // R3 own address only
                  // R20 foreign address stays silent
                  if (rx[7:1] != smb_cfg_pkg::DEV_ADDR) begin
                    next_st.state = ST_SKIP;
                  end
                  next_st.rd   = rx[0];
                  next_st.kind = K_CMD;
                end
                K_CMD: begin
                  // R4 bit 7 selects byte or block
                  // R5 index from bits 6:0
                  next_st.index      = rx[smb_cfg_pkg::CMD_BYTE_MODE_BIT] ? rx[6:0] : 7'h00;
                  next_st.send_count = !rx[smb_cfg_pkg::CMD_BYTE_MODE_BIT];
                  // R7 count phase skipped
                  next_st.kind = (!rx[smb_cfg_pkg::CMD_BYTE_MODE_BIT] && !count_skip)
                                 ? K_COUNT : K_DATA;
                end
                K_COUNT: begin
                  next_st.kind = K_DATA;
                end
                K_DATA: begin
                  // R10 data byte stored then acked
                  if (st.index == 7'h00) begin
                    // R15 software can set but never clear
                    // R16 main source select
                    // R17 serial ata select
                    next_st.regs[0] = {3'h0, st.regs[0][smb_cfg_pkg::MGMT_BIT] |
                                       rx[smb_cfg_pkg::MGMT_BIT], 1'b0, rx[2:0]};
                  end else if (int'(st.index) < REG_BYTES) begin
                    next_st.regs[st.index] = rx;
                  end
                  next_st.index = st.index + 7'h01;
                end
                default: next_st.state = ST_SKIP;
              endcase
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            if (st.cnt == 4'h8) begin
              // R6 acknowledge every received byte except a foreign address
              next_st.sda_oe = 1'b1;
              next_st.cnt    = 4'h9;
            end else begin
              next_st.sda_oe = 1'b0;
              if (st.rd) begin
                // R8 read address acked, transmit starts
                load = 1'b1;
              end else begin
                next_st.state = ST_RX;
                next_st.cnt   = 4'h0;
              end
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (st.cnt == 4'h7) begin
              next_st.sda_oe = 1'b0;
              next_st.state  = ST_HACK;
            end else begin
              next_st.shift  = {st.shift[6:0], 1'b0};
              next_st.sda_oe = !st.shift[6];
              next_st.cnt    = st.cnt + 4'h1;
            end
          end
        end
        ST_HACK: begin
          // R9 not-acknowledge ends the read
          if (rise) begin
            if (sda) begin
              next_st.state = ST_SKIP;
            end else begin
              next_st.cnt = 4'h8;
            end
          end else if (fall && st.cnt == 4'h8) begin
            load = 1'b1;
          end
        end
        ST_IDLE, ST_SKIP: begin
        end
        default: next_st.state = ST_IDLE;
      endcase
    end
    if (load) begin
      // R11 data msb first, index advances per byte
      next_st.state  = ST_TX;
      next_st.cnt    = 4'h0;
      next_st.shift  = tx;
      next_st.sda_oe = !tx[7];
      if (st.send_count) begin
        next_st.send_count = 1'b0;
      end else begin
        next_st.index = st.index + 7'h01;
      end
    end
    // R18 powerdown reloads defaults except management bit, unless retained
    if (pd && !st.regs[0][smb_cfg_pkg::RETAIN_BIT]) begin
      next_st.regs = REGS_RESET;
      next_st.regs[0][smb_cfg_pkg::MGMT_BIT] = st.regs[0][smb_cfg_pkg::MGMT_BIT];
    end
    // R15 pin request sets the sticky bit
    if (mgmt_req) begin
      next_st.regs[0][smb_cfg_pkg::MGMT_BIT] = 1'b1;
    end
    // R19 one-shot latch, repeatable in test mode
    if (pg && (!st.fs_taken || tmode)) begin
      next_st.fs       = fs_pin;
      next_st.fs_taken = 1'b1;
    end
  end

  // R12 defaults loaded at reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= DEV_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    config_bytes    = st.regs;
    config_bytes[0] = byte0_view(st);
  end

  assign link.dev_sda_out         = 1'b0;
  assign link.dev_sda_oe          = st.sda_oe;
  assign mgmt_mode_enable         = st.regs[0][smb_cfg_pkg::MGMT_BIT];
  assign main_source_select       = st.regs[0][smb_cfg_pkg::MAIN_SEL_BIT];
  assign serial_ata_clock_select  = st.regs[0][smb_cfg_pkg::SERIAL_ATA_CLOCK_SELECT_BIT];
  assign powerdown_config_retain  = st.regs[0][smb_cfg_pkg::RETAIN_BIT];
  assign cpu_freq_latched         = st.fs;
endmodule

/* File: core/smb_cfg_host.sv */
// host end: drives the two-wire link for byte and block transfers
`timescale 1ns/1ps
module smb_cfg_host #(
  parameter int QUARTER_CYCLES = smb_cfg_pkg::SCL_QUARTER_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  smb_link_if.host               link,
  input  wire logic              start_req,
  input  wire smb_cfg_pkg::op_t  op,
  input  wire logic [6:0]        index,
  input  wire logic [7:0]        count,
  input  wire logic              skip_count,
  input  wire logic [7:0]        wr_data,
  output logic                   busy,
  output logic                   wr_taken,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic                   done,
  output logic                   nacked
);
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_WBYTE = 5'h04,
    H_RBYTE = 5'h08,
    H_STOP  = 5'h10
  } hstate_t;

  typedef enum logic [6:0] {
    P_ADDR_W = 7'h01,
    P_CMD    = 7'h02,
    P_COUNT  = 7'h04,
    P_WDATA  = 7'h08,
    P_ADDR_R = 7'h10,
    P_RCOUNT = 7'h20,
    P_RDATA  = 7'h40
  } phase_t;

  typedef struct packed {
    hstate_t          state;
    phase_t           phase;
    smb_cfg_pkg::op_t op;
    logic [6:0]       index;
    logic [7:0]       remaining;
    logic [7:0]       shift;
    logic [3:0]       cnt;
    logic [1:0]       quarter;
    logic [15:0]      div;
    logic             scl;
    logic             sda_oe;
    logic             nak;
    logic [7:0]       rd_data;
    logic             rd_valid;
    logic             wr_taken;
    logic             done;
    logic             nacked;
  } host_t;

  localparam logic [15:0] QLAST = 16'(QUARTER_CYCLES - 1);
  localparam host_t HOST_RESET = '{state: H_IDLE, phase: P_ADDR_W, op: smb_cfg_pkg::OP_BYTE_WRITE,
                                   scl: 1'b1, default: '0};

  host_t st;
  host_t next_st;
  logic  sda;

  pin_sync #(.WIDTH(1), .RESET_LEVEL(1'b1)) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pin     (link.sda),
    .level   (sda)
  );

  always_comb begin
    logic is_read;
    logic is_block;
    is_read  = (st.op == smb_cfg_pkg::OP_BYTE_READ) || (st.op == smb_cfg_pkg::OP_BLOCK_READ);
    is_block = (st.op == smb_cfg_pkg::OP_BLOCK_WRITE) || (st.op == smb_cfg_pkg::OP_BLOCK_READ);
    next_st          = st;
    next_st.rd_valid = 1'b0;
    next_st.wr_taken = 1'b0;
    next_st.done     = 1'b0;
    if (st.state == H_IDLE) begin
      next_st.div     = 16'h0000;
      next_st.quarter = 2'h0;
      if (start_req) begin
        next_st.state     = H_START;
        next_st.phase     = P_ADDR_W;
        next_st.op        = op;
        next_st.index     = index;
        next_st.nacked    = 1'b0;
        next_st.remaining = (op == smb_cfg_pkg::OP_BYTE_WRITE || op == smb_cfg_pkg::OP_BYTE_READ
                             || count == 8'h00) ? 8'h01 : count;
      end
    end else if (st.div != QLAST) begin
      next_st.div = st.div + 16'h0001;
    end else begin
      next_st.div     = 16'h0000;
      next_st.quarter = st.quarter + 2'h1;
      unique case (st.quarter)
        2'h0: next_st.scl = 1'b1;
        2'h1: begin
          // middle of the high phase: start/stop edges and sampling
          if (st.state == H_START) begin
            next_st.sda_oe = 1'b1;
          end else if (st.state == H_STOP) begin
            next_st.sda_oe = 1'b0;
          end else if (st.state == H_WBYTE && st.cnt == 4'h8) begin
            next_st.nak = sda;
          end else if (st.state == H_RBYTE && st.cnt != 4'h8) begin
            next_st.shift = {st.shift[6:0], sda};
          end
        end
        2'h2: next_st.scl = (st.state == H_STOP);
        2'h3: begin
          next_st.cnt = st.cnt + 4'h1;
          unique case (st.state)
            H_START: begin
              next_st.state = H_WBYTE;
              next_st.cnt   = 4'h0;
              next_st.shift = {smb_cfg_pkg::DEV_ADDR, st.phase == P_ADDR_R};
            end
            H_WBYTE: begin
              if (st.cnt != 4'h8) begin
                next_st.shift = {st.shift[6:0], 1'b0};
              end else if (st.nak) begin
                next_st.nacked = 1'b1;
                next_st.state  = H_STOP;
              end else begin
                next_st.cnt = 4'h0;
                unique case (st.phase)
                  P_ADDR_W: begin
                    // byte ops carry the index, block ops send zeros
                    next_st.phase = P_CMD;
                    next_st.shift = is_block ? 8'h00 : {1'b1, st.index};
                  end
                  P_CMD: begin
                    if (is_read) begin
                      next_st.state = H_START;
                      next_st.phase = P_ADDR_R;
                    end else if (is_block && !skip_count) begin
                      next_st.phase = P_COUNT;
                      next_st.shift = st.remaining;
                    end else begin
                      next_st.phase    = P_WDATA;
                      next_st.shift    = wr_data;
                      next_st.wr_taken = 1'b1;
                    end
                  end
                  P_COUNT: begin
                    next_st.phase    = P_WDATA;
                    next_st.shift    = wr_data;
                    next_st.wr_taken = 1'b1;
                  end
                  P_WDATA: begin
                    if (st.remaining == 8'h01) begin
                      next_st.state = H_STOP;
                    end else begin
                      next_st.remaining = st.remaining - 8'h01;
                      next_st.shift     = wr_data;
                      next_st.wr_taken  = 1'b1;
                    end
                  end
                  P_ADDR_R: begin
                    next_st.state = H_RBYTE;
                    next_st.phase = is_block ? P_RCOUNT : P_RDATA;
                  end
                  default: next_st.state = H_STOP;
                endcase
              end
            end
            H_RBYTE: begin
              if (st.cnt == 4'h8) begin
                next_st.cnt = 4'h0;
                if (st.phase == P_RCOUNT) begin
                  next_st.phase = P_RDATA;
                end else if (st.remaining == 8'h01) begin
                  next_st.rd_data  = st.shift;
                  next_st.rd_valid = 1'b1;
                  next_st.state    = H_STOP;
                end else begin
                  next_st.rd_data   = st.shift;
                  next_st.rd_valid  = 1'b1;
                  next_st.remaining = st.remaining - 8'h01;
                end
              end
            end
            H_STOP: begin
              next_st.state = H_IDLE;
              next_st.done  = 1'b1;
            end
            default: next_st.state = H_IDLE;
          endcase
          // data line for the slot now beginning, changed only while scl is low
          unique case (next_st.state)
            H_START: next_st.sda_oe = 1'b0;
            H_STOP:  next_st.sda_oe = 1'b1;
            H_WBYTE: next_st.sda_oe = (next_st.cnt != 4'h8) && !next_st.shift[7];
            H_RBYTE: next_st.sda_oe = (next_st.cnt == 4'h8) &&
                                      (next_st.phase == P_RCOUNT || next_st.remaining != 8'h01);
            default: next_st.sda_oe = 1'b0;
          endcase
        end
        default: next_st.scl = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= HOST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign link.scl          = st.scl;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe  = st.sda_oe;
  assign busy              = (st.state != H_IDLE);
  assign wr_taken          = st.wr_taken;
  assign rd_data           = st.rd_data;
  assign rd_valid          = st.rd_valid;
  assign done              = st.done;
  assign nacked            = st.nacked;
endmodule

/* File: verif/smb_link_checker.sv */
// wire-level assertions for the two-wire link
`timescale 1ns/1ps
module smb_link_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_out,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  a_dev_open_drain: assert property (!dev_sda_out)
    else $error("device drove sda high");
  a_host_open_drain: assert property (!host_sda_out)
    else $error("host drove sda high");
  a_drive_after_fall: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 3))
    else $error("device drive near scl edge");
  a_drive_whole_bit: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device drive too short");
  a_release_scl_low: assert property ($fell(dev_sda_oe) |-> !scl && !$past(scl, 3))
    else $error("device release near scl edge");
  a_stable_scl_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device sda moved with scl high");
  a_scl_high_span: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high too short");
  a_scl_low_span: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low too short");
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
  cover property ($rose(dev_sda_oe));
endmodule

/* File: verif/testbench.sv */
// bench: host end and slave end joined by one link
`timescale 1ns/1ps
module testbench;
  logic            sys_clk, rst_b, start_req, skip, cs, pg, mr, pd;
  logic            wr_taken, rd_valid, done, nacked, mgmt, msel, ssel, keep, busy, tm;
  logic [1:0]      op;
  logic [2:0]      fs, fsl;
  logic [6:0]      index;
  logic [7:0]      count, wr_data, rd_data;
  logic [3:0][7:0] cfg;
  logic [7:0]      wq [8] = '{8'hff, 8'h00, 8'h5a, 8'h11, 8'h22, 8'h00, 8'h33, 8'h00};
  logic [7:0]      rd [4] = '{8'hb0, 8'h33, 8'h5a, 8'hff};
  logic [7:0]      rq [$];
  int              widx = 0;
  int              errors = 0;
  int              checked = 0;
  smb_link_if link ();
  smb_cfg_host #(.QUARTER_CYCLES(16)) u_smb_cfg_host (.sys_clk(sys_clk), .rst_b(rst_b),
    .link(link.host), .start_req(start_req), .op(smb_cfg_pkg::op_t'(op)), .index(index),
    .count(count), .skip_count(skip), .wr_data(wr_data), .busy(busy), .wr_taken(wr_taken),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nacked(nacked));
  smb_cfg_slave u_smb_cfg_slave (.sys_clk(sys_clk), .rst_b(rst_b), .link(link.device),
    .count_skip(cs), .power_good_strobe(pg), .cpu_freq_select_high(fs[2]),
    .cpu_freq_select_mid(fs[1]), .cpu_freq_select_low(fs[0]), .test_mode(tm),
    .mgmt_pin_request(mr), .power_down(pd), .mgmt_mode_enable(mgmt),
    .main_source_select(msel), .serial_ata_clock_select(ssel),
    .powerdown_config_retain(keep), .cpu_freq_latched(fsl), .config_bytes(cfg));
  smb_link_checker u_smb_link_checker (.sys_clk(sys_clk), .rst_b(rst_b), .scl(link.scl),
    .sda(link.sda), .host_sda_out(link.host_sda_out), .dev_sda_out(link.dev_sda_out),
    .dev_sda_oe(link.dev_sda_oe));
  // next write byte moves only after the host has sampled the current one
  always @(negedge sys_clk) begin
    wr_data <= wq[widx];
    if (wr_taken) widx <= widx + 1;
    if (rd_valid) rq.push_back(rd_data);
  end
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic [1:0] o, input logic [6:0] i, input logic [7:0] n);
    op = o;
    index = i;
    count = n;
    start_req = 1'b1;
    idle(1);
    start_req = 1'b0;
    check({7'h0, busy}, 8'h01);
    repeat (9000) begin
      idle(1);
      if (done) break;
    end
    check({5'h0, busy, done, nacked}, 8'h02);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #(60000 * 25);
    errors++;
    wrap_up();
  end
  initial begin
    {rst_b, start_req, skip, cs, pg, mr, pd, tm, op, fs, index, count} = '0;
    idle(10);
    rst_b = 1'b1;
    idle(2);
    check(cfg[0], 8'h01);
    check(cfg[1], 8'h03);
    fs = 3'b101;
    pg = 1'b1;
    idle(20);
    fs = 3'b010;
    idle(20);
    check({5'h0, fsl}, 8'h05);
    $display("power-up test over");
    // all register traffic stays in the set-up phase
    xfer(2'h0, 7'h0, 8'h1);
    check(cfg[0], 8'hb7);
    check({4'h0, mgmt, msel, ssel, keep}, 8'h0f);
    xfer(2'h0, 7'h0, 8'h1);
    check(cfg[0], 8'hb0);
    xfer(2'h0, 7'h2, 8'h1);
    check(cfg[2], 8'h5a);
    xfer(2'h1, 7'h0, 8'h1);
    check(rq.pop_front(), 8'hb0);
    $display("byte test over");
    xfer(2'h2, 7'h0, 8'h2);
    check(cfg[1], 8'h22);
    {cs, skip} = 2'h3;
    xfer(2'h2, 7'h0, 8'h2);
    check(cfg[0], 8'hb0);
    check(cfg[1], 8'h33);
    {cs, skip} = 2'h0;
    xfer(2'h3, 7'h0, 8'h4);
    foreach (rd[k]) check(rq.pop_front(), rd[k]);
    $display("block test over");
    pd = 1'b1;
    idle(20);
    check(cfg[1], 8'h03);
    check(cfg[0], 8'hb1);
    {pd, pg} = 2'h0;
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
    idle(2);
    check(cfg[0], 8'h01);
    mr = 1'b1;
    idle(20);
    mr = 1'b0;
    idle(20);
    check(cfg[0], 8'h11);
    {tm, pg, fs} = 5'b1_1_010;
    idle(20);
    fs = 3'b110;
    idle(20);
    check({5'h0, fsl}, 8'h06);
    {tm, fs} = 4'b0_111;
    idle(20);
    check({5'h0, fsl}, 8'h06);
    $display("power-down test over");
    wrap_up();
  end
endmodule
